// ==== design/aps_cfg.svh ====
`ifndef APS_CFG_SVH
`define APS_CFG_SVH

`define APS_CLK_HZ            10000000
`define APS_DEGLITCH_NS       2000
`define APS_DEGLITCH_CYC      ((`APS_DEGLITCH_NS * (`APS_CLK_HZ / 1000000) + 999) / 1000)
`define APS_SLEEP_DLY_US      200
`define APS_SLEEP_DLY_CYC     (`APS_SLEEP_DLY_US * (`APS_CLK_HZ / 1000000))
`define APS_LATCH_MS          3
`define APS_LATCH_CYC         (`APS_LATCH_MS * (`APS_CLK_HZ / 1000))
`define APS_WAKE_MS           25
`define APS_WAKE_CYC          (`APS_WAKE_MS * (`APS_CLK_HZ / 1000))
`define APS_CNT_W             24

`define APS_REG_CTRL          32'h0000_0000
`define APS_REG_STATUS        32'h0000_0004
`define APS_CTRL_RST          32'h0000_0000
`define APS_CTRL_SOFT_SD_BIT  0
`define APS_CTRL_THERM_EN_BIT 1

`endif

// ==== design/aps_pkg.sv ====
`include "aps_cfg.svh"

package aps_pkg;
   typedef enum logic [7:0] {
      APS_OFF      = 8'h01,
      APS_SB_RAMP  = 8'h02,
      APS_SB_WAIT  = 8'h04,
      APS_MAIN_RMP = 8'h08,
      APS_SLEEP    = 8'h10,
      APS_WAKE_DLY = 8'h20,
      APS_ACT_RMP  = 8'h40,
      APS_ACTIVE   = 8'h80
   } aps_state_t;

   typedef enum logic [1:0] {
      APS_SL_NONE = 2'h0,
      APS_SL_S3   = 2'h1,
      APS_SL_S5   = 2'h2
   } aps_sleep_t;

   // Comparator event inputs from the analog front end
   typedef struct packed {
      logic bias_por_ok;
      logic ss_low;
      logic ss_at_125;
      logic ss_at_245;
      logic ss_at_275;
      logic main_in_ok;
      logic temp_140;
      logic temp_155;
      logic mem_sel_low;
      logic mem_sel_high;
   } aps_sense_t;

   // Undervoltage flags, one per output
   typedef struct packed {
      logic dual3;
      logic mem25;
      logic mem33;
      logic clk25;
      logic dual5;
   } aps_uv_t;

   typedef struct packed {
      logic dual3_on;
      logic mem25_on;
      logic mem33_on;
      logic clk_on;
      logic dual5_on;
      logic switch_on;
      logic ss_fast_charge;
      logic ss_disch_125;
      logic ss_disch_245;
   } aps_drive_t;

   typedef struct packed {
      aps_state_t state;
      aps_sleep_t sleep;
      logic [`APS_CNT_W-1:0] cnt;
      logic [`APS_CNT_W-1:0] dly;
      logic       dly_run;
      logic [7:0] gs3;
      logic [7:0] gs5;
      logic       s3_f;
      logic       s5_f;
      logic       en5_lat;
      logic       memory_voltage_select_lo;
      logic       memory_voltage_select_hi;
      logic       uv_dual3_en;
      logic       uv_all_en;
      logic       latch_off;
      logic       forced_s5;
      logic       therm_sd;
      logic [4:0] reg_off;
      logic       fault;
      logic       en5_window;
      aps_drive_t drv;
   } aps_st_t;
endpackage

// ==== design/aps_sequencer.sv ====
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "aps_cfg.svh"

// Behaviour
// - Start standby ramp after bias passes reset
// - Enable low: dual five off in sleep
// - Enable high: dual five on in sleep
// - Soft-off low with suspend high: hold
// - Only active to sleep and back
// - Enable accepted only in permitted windows
// - Deglitch both sleep request inputs
// - Suspend low starts 200us, then S5/S3
// - Standby ramp done: enable UV, discharge
// - After 3ms latch selects, ramp rest
// - All regulated: enable monitors, hold 1.25V
// - Active wake waits 25ms after inputs
// - Standby rail up regardless of requests
// - Wake timeout: ramp memory, clock, switches
// - Active ramp done: hold node 2.45V
// - Any output undervoltage raises fault
// - Clock regulator fault turns it off; memory regulators only in sleep
// - Node pulled low: shut all, clear
// - Early standby undervoltage latches off
// - Thermal fault 140, shutdown 155, resume
// - Input loss forces S5 until recovery
// - Memory select latched at defined points
// - Memory select picks memory rails
// - Node release restarts soft-start
module aps_sequencer
   import aps_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        suspend_ram_req_n,
   input  wire logic        soft_off_req_n,
   input  wire logic        dual5_sleep_support_en,
   input  wire aps_sense_t  sense,
   input  wire aps_uv_t     uv,
   output      aps_drive_t  drive,
   output      logic        fault_report,
   output      logic        active_switch_drive,
   output      logic        clock_rail_out,
   output      logic        dual_five_rail,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam logic [`APS_CNT_W-1:0] DEG_CYC   = `APS_CNT_W'(`APS_DEGLITCH_CYC);
   localparam logic [`APS_CNT_W-1:0] SLP_CYC   = `APS_CNT_W'(`APS_SLEEP_DLY_CYC);
   localparam logic [`APS_CNT_W-1:0] LATCH_CYC = `APS_CNT_W'(`APS_LATCH_CYC);
   localparam logic [`APS_CNT_W-1:0] WAKE_CYC  = `APS_CNT_W'(`APS_WAKE_CYC);

   // Pin synchronisers: asynchronous pins and comparators
   logic [1:0]  s3_sync;
   logic [1:0]  s5_sync;
   logic [1:0]  en5_sync;
   aps_sense_t  sense_m;
   aps_sense_t  sense_s;
   aps_uv_t     uv_m;
   aps_uv_t     uv_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s3_sync  <= 2'h3;
         s5_sync  <= 2'h3;
         en5_sync <= 2'h3;
         sense_m  <= '0;
         sense_s  <= '0;
         uv_m     <= '0;
         uv_s     <= '0;
      end else begin
         s3_sync  <= {s3_sync[0], suspend_ram_req_n};
         s5_sync  <= {s5_sync[0], soft_off_req_n};
         en5_sync <= {en5_sync[0], dual5_sleep_support_en};
         sense_m  <= sense;
         sense_s  <= sense_m;
         uv_m     <= uv;
         uv_s     <= uv_m;
      end
   end

   // Bus registers
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic        aw_held_reg, w_held_reg;
   logic [31:0] awaddr_reg, wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg, rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  bresp_reg, rresp_reg;

   aps_st_t st_reg;
   aps_st_t st_next;

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready  = !w_held_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   logic [31:0] status_word;
   assign status_word = {st_reg.state, 6'h00, st_reg.sleep, 8'h00,
                         st_reg.therm_sd, st_reg.forced_s5, st_reg.latch_off,
                         st_reg.en5_lat, st_reg.memory_voltage_select_hi, st_reg.memory_voltage_select_lo,
                         st_reg.uv_all_en, st_reg.fault};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg    <= `APS_CTRL_RST;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 32'h0;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0;
         rresp_reg   <= 2'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (aw_held_reg && w_held_reg) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= (awaddr_reg[31:2] == `APS_REG_CTRL >> 2) ? 2'h0 : 2'h2;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= 2'h0;
            if (s_axi_araddr[31:2] == `APS_REG_CTRL >> 2) begin
               rdata_reg <= ctrl_reg;
            end else if (s_axi_araddr[31:2] == `APS_REG_STATUS >> 2) begin
               rdata_reg <= status_word;
            end else begin
               rdata_reg <= 32'h0;
               rresp_reg <= 2'h2;
            end
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      ctrl_next = ctrl_reg;
      if (aw_held_reg && w_held_reg && awaddr_reg[31:2] == `APS_REG_CTRL >> 2) begin
         for (int i = 0; i < 4; i++) begin
            if (wstrb_reg[i]) begin
               ctrl_next[i*8 +: 8] = wdata_reg[i*8 +: 8];
            end
         end
         ctrl_next[31:2] = 30'h0;
      end
   end

   // Sequencer
   logic soft_sd;
   logic ss_shut;
   logic int_fault;
   assign soft_sd = ctrl_reg[`APS_CTRL_SOFT_SD_BIT];

   always_comb begin
      st_next = st_reg;
      ss_shut = sense_s.ss_low || soft_sd;

      // Deglitch: a level must persist before it is accepted
      st_next.gs3 = (s3_sync[1] == st_reg.s3_f) ? 8'h00 : st_reg.gs3 + 8'h01;
      st_next.gs5 = (s5_sync[1] == st_reg.s5_f) ? 8'h00 : st_reg.gs5 + 8'h01;
      if ({16'h0, st_reg.gs3} >= DEG_CYC - 1) begin
         st_next.s3_f = s3_sync[1];
         st_next.gs3  = 8'h00;
      end
      if ({16'h0, st_reg.gs5} >= DEG_CYC - 1) begin
         st_next.s5_f = s5_sync[1];
         st_next.gs5  = 8'h00;
      end

      st_next.en5_window = (st_reg.state inside {APS_ACTIVE, APS_SB_WAIT}) || ss_shut
                           || !sense_s.bias_por_ok;
      if (st_next.en5_window) begin
         st_next.en5_lat = en5_sync[1];
      end

      if (st_reg.cnt != '0) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end

      // Thermal hysteresis; shutdown released at the fault level
      if (sense_s.temp_155) begin
         st_next.therm_sd = 1'b1;
      end else if (!sense_s.temp_140) begin
         st_next.therm_sd = 1'b0;
      end

      // Forced S5 on main input loss while active
      if (st_reg.state inside {APS_ACTIVE, APS_ACT_RMP} && !sense_s.main_in_ok) begin
         st_next.forced_s5 = 1'b1;
      end else if (sense_s.main_in_ok || ss_shut) begin
         st_next.forced_s5 = 1'b0;
      end

      // Clock regulator latches off on its own undervoltage, memory regulators only in sleep
      if (st_reg.uv_all_en) begin
         if (uv_s.mem25 && st_reg.sleep != APS_SL_NONE) st_next.reg_off[3] = 1'b1;
         if (uv_s.mem33 && st_reg.sleep != APS_SL_NONE) st_next.reg_off[2] = 1'b1;
         if (uv_s.clk25) st_next.reg_off[1] = 1'b1;
      end

      if (st_reg.uv_dual3_en && !st_reg.uv_all_en && uv_s.dual3) begin
         st_next.latch_off = 1'b1;
      end

      case (st_reg.state)
         APS_OFF: begin
            st_next.sleep     = APS_SL_NONE;
            st_next.uv_dual3_en = 1'b0;
            st_next.uv_all_en = 1'b0;
            if (sense_s.bias_por_ok && !ss_shut && !st_reg.therm_sd && !st_reg.latch_off) begin
               st_next.state = APS_SB_RAMP;
            end
         end
         APS_SB_RAMP: begin
            if (sense_s.ss_at_275 && !uv_s.dual3) begin
               st_next.uv_dual3_en = 1'b1;
               st_next.state       = APS_SB_WAIT;
               st_next.cnt         = LATCH_CYC;
            end
         end
         APS_SB_WAIT: begin
            if (st_reg.cnt == '0 && sense_s.ss_at_125) begin
               st_next.memory_voltage_select_lo = sense_s.mem_sel_low;
               st_next.memory_voltage_select_hi = sense_s.mem_sel_high;
               if (st_reg.s3_f && st_reg.s5_f) begin
                  st_next.state = APS_WAKE_DLY;
                  st_next.cnt   = WAKE_CYC;
               end else begin
                  st_next.sleep = (!st_reg.s5_f) ? APS_SL_S5 : APS_SL_S3;
                  st_next.state = APS_MAIN_RMP;
               end
            end
         end
         APS_MAIN_RMP: begin
            if (sense_s.ss_at_275) begin
               st_next.uv_all_en = 1'b1;
               st_next.state     = APS_SLEEP;
            end
         end
         APS_SLEEP: begin
            // Only a full wake request leaves sleep; S3 and S5 never swap
            if (st_reg.s3_f && st_reg.s5_f && !st_reg.forced_s5) begin
               if (st_reg.sleep == APS_SL_S5) begin
                  st_next.memory_voltage_select_lo = sense_s.mem_sel_low;
                  st_next.memory_voltage_select_hi = sense_s.mem_sel_high;
               end
               st_next.state     = APS_WAKE_DLY;
               st_next.cnt       = WAKE_CYC;
               st_next.uv_all_en = 1'b0;
            end
         end
         APS_WAKE_DLY: begin
            if (!sense_s.main_in_ok) begin
               st_next.cnt = WAKE_CYC;
            end else if (st_reg.cnt == '0) begin
               st_next.sleep = APS_SL_NONE;
               st_next.state = APS_ACT_RMP;
            end
         end
         APS_ACT_RMP: begin
            if (sense_s.ss_at_275) begin
               st_next.uv_all_en = 1'b1;
               st_next.state     = APS_ACTIVE;
            end
         end
         APS_ACTIVE: begin
            if (st_reg.forced_s5) begin
               st_next.sleep   = APS_SL_S5;
               st_next.state   = APS_SLEEP;
               st_next.dly_run = 1'b0;
            end else if (!st_reg.s3_f && !st_reg.dly_run) begin
               st_next.dly_run = 1'b1;
               st_next.dly     = SLP_CYC;
            end else if (st_reg.dly_run) begin
               if (st_reg.s3_f) begin
                  st_next.dly_run = 1'b0;
               end else if (st_reg.dly == '0) begin
                  st_next.dly_run = 1'b0;
                  st_next.sleep   = st_reg.s5_f ? APS_SL_S3 : APS_SL_S5;
                  st_next.state   = APS_SLEEP;
               end else begin
                  st_next.dly = st_reg.dly - 1'b1;
               end
            end
            // Soft-off low with suspend high is illegal: state is kept
         end
         default: st_next.state = APS_OFF;
      endcase

      if (ss_shut || !sense_s.bias_por_ok || st_reg.therm_sd || st_reg.latch_off) begin
         st_next.state     = APS_OFF;
         st_next.sleep     = APS_SL_NONE;
         st_next.uv_dual3_en = 1'b0;
         st_next.uv_all_en = 1'b0;
         st_next.dly_run   = 1'b0;
         st_next.reg_off   = 5'h00;
      end
      if (!sense_s.bias_por_ok) begin
         st_next.latch_off = 1'b0;
         st_next.forced_s5 = 1'b0;
      end

      // Drive outputs derived from next state; fault from current state and inputs
      int_fault = (st_reg.uv_dual3_en && uv_s.dual3)
                  || (st_reg.uv_all_en && (|{uv_s.mem25, uv_s.mem33, uv_s.clk25, uv_s.dual5}))
                  || !sense_s.main_in_ok && st_reg.state == APS_ACTIVE
                  || sense_s.temp_140 || st_reg.latch_off || st_reg.forced_s5;
      st_next.fault = int_fault && !ss_shut;

      st_next.drv = '0;
      if (st_next.state != APS_OFF) begin
         st_next.drv.dual3_on = 1'b1;
         st_next.drv.ss_fast_charge = (st_next.state == APS_SB_RAMP);
         st_next.drv.ss_disch_125 = st_next.state inside {APS_SB_WAIT, APS_SLEEP};
         st_next.drv.ss_disch_245 = (st_next.state == APS_ACTIVE);
         if (st_next.state inside {APS_ACT_RMP, APS_ACTIVE}) begin
            st_next.drv.switch_on = 1'b1;
            st_next.drv.clk_on    = !st_next.reg_off[1];
            st_next.drv.mem25_on  = !st_next.memory_voltage_select_hi;
            st_next.drv.mem33_on  = 1'b1;
            st_next.drv.dual5_on  = 1'b1;
         end else if (st_next.sleep != APS_SL_NONE) begin
            // Sleep rails stay up through the wake delay until the handover
            st_next.drv.mem25_on = !st_next.memory_voltage_select_hi && !st_next.reg_off[3];
            st_next.drv.mem33_on = !st_next.memory_voltage_select_lo && !st_next.reg_off[2];
            st_next.drv.dual5_on = st_next.en5_lat;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg       <= '0;
         st_reg.state <= APS_OFF;
         st_reg.s3_f  <= 1'b1;
         st_reg.s5_f  <= 1'b1;
         st_reg.en5_lat <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign drive               = st_reg.drv;
   assign fault_report        = st_reg.fault;
   assign active_switch_drive = st_reg.drv.switch_on;
   assign clock_rail_out      = st_reg.drv.clk_on;
   assign dual_five_rail      = st_reg.drv.dual5_on;
endmodule

// ==== tb/aps_sequencer_properties.sv ====
`timescale 1ns/100ps
module aps_sequencer_properties
   import aps_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire aps_sense_t sense,
   input  wire aps_uv_t    uv,
   input  wire aps_drive_t drive,
   input  wire logic       fault_report,
   input  wire logic       active_switch_drive,
   input  wire logic       clock_rail_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   wire rails = drive.dual3_on | drive.mem25_on | drive.mem33_on | drive.clk_on
              | drive.dual5_on | drive.switch_on;

   // Six samples cover two sync stages plus state and drive registers
   property p_gnd_off;
      sense.ss_low [*6] |-> !rails && !fault_report;
   endproperty
   a_gnd_off: assert property (p_gnd_off)
      else $error("rail or fault up while node grounded");

   property p_bias_off;
      !sense.bias_por_ok [*6] |-> !rails;
   endproperty
   a_bias_off: assert property (p_bias_off)
      else $error("rail up without bias");

   property p_main_off;
      !sense.main_in_ok [*6] |-> !active_switch_drive && !clock_rail_out;
   endproperty
   a_main_off: assert property (p_main_off)
      else $error("switch or clock rail on without main inputs");

   property p_hot_off;
      sense.temp_155 [*6] |-> !rails;
   endproperty
   a_hot_off: assert property (p_hot_off)
      else $error("rails on above shutdown temperature");

   property p_hot_flag;
      (sense.temp_140 && sense.bias_por_ok && !sense.ss_low) [*6] |-> fault_report;
   endproperty
   a_hot_flag: assert property (p_hot_flag)
      else $error("no fault flag at high temperature");

   property p_uv_flag;
      (|uv && drive.ss_disch_125 && !sense.ss_low) [*6] |-> fault_report;
   endproperty
   a_uv_flag: assert property (p_uv_flag)
      else $error("no fault flag on undervoltage");

   property p_mem_off;
      (uv.mem25 && drive.ss_disch_125) [*6] |-> !drive.mem25_on;
   endproperty
   a_mem_off: assert property (p_mem_off)
      else $error("internal regulator kept on after undervoltage");

   property p_disch;
      $rose(drive.ss_disch_125) |-> drive.dual3_on;
   endproperty
   a_disch: assert property (p_disch)
      else $error("node discharge without standby rail");

   c_sleep: cover property (drive.ss_disch_125 && drive.mem25_on);
   c_fault: cover property ($rose(fault_report));
   c_hot:   cover property (sense.temp_155 && !rails);
endmodule

// ==== tb/aps_far_end.sv ====
`timescale 1ns/100ps
module aps_far_end
   import aps_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       bias_on,
   input  wire logic       ss_gnd,
   input  wire logic       atx_on,
   input  wire logic [1:0] hot,
   input  wire logic [1:0] memory_voltage_select,
   input  wire aps_drive_t drive,
   output      aps_sense_t sense
);
   int node = 0;

   // Node in 10 mV steps; discharge 5 per cycle, charge 5 per cycle below 100 and 1 above
   always @(posedge aclk) begin
      if (!bias_on || ss_gnd) begin
         node <= 0;
      end else if ((drive.ss_disch_125 && node > 125) || (drive.ss_disch_245 && node > 245)) begin
         node <= node - 5;
      end else if (drive.ss_disch_125 || drive.ss_disch_245) begin
         node <= node;
      end else if (node < 300) begin
         node <= node + ((node < 100) ? 5 : 1);
      end
   end

   assign sense = {bias_on, ss_gnd, node <= 130, node <= 250, node >= 275, atx_on,
                   hot[0], hot[1], memory_voltage_select[0], memory_voltage_select[1]};
endmodule

// ==== tb/aps_sequencer_tb.sv ====
`timescale 1ns/100ps
module aps_sequencer_tb
   import aps_pkg::*;
;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic        suspend_ram_req_n = 1'h0, soft_off_req_n = 1'h1;
   logic        dual5_sleep_support_en = 1'h0;
   logic        bias_on = 1'h1, ss_gnd = 1'h0, atx_on = 1'h0;
   logic [1:0]  hot = 2'h0, memory_voltage_select = 2'h1;
   aps_uv_t     uv = '0;
   aps_sense_t  sense;
   aps_drive_t  drive;
   logic        fault_report, active_switch_drive, clock_rail_out, dual_five_rail;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, q;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   int          err_total = 0, check_count = 0;

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

   aps_sequencer DUT (.aclk, .aresetn, .suspend_ram_req_n, .soft_off_req_n,
      .dual5_sleep_support_en, .sense, .uv, .drive, .fault_report, .active_switch_drive,
      .clock_rail_out, .dual_five_rail, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   aps_far_end u_far (.aclk, .bias_on, .ss_gnd, .atx_on, .hot, .memory_voltage_select, .drive, .sense);

   initial begin
      forever #50 aclk = ~aclk;
   end

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One access; ready sampled before the edge's updates land
   task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rq, output logic [1:0] rr);
      int n;
      @(posedge aclk);
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
      end
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_bvalid && s_axi_bready) begin
            rr = s_axi_bresp;
            break;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            rq = s_axi_rdata;
            rr = s_axi_rresp;
            break;
         end
      end
      s_axi_bready <= 1'h0;
      s_axi_rready <= 1'h0;
      if (n == 64) err_total++;
   endtask

   task automatic stat(input logic [31:0] e);
      axi(1'h0, 32'h4, 32'h0, q, r);
      `CHK(q, e)
   endtask

   // Poll the state field; the standby wait alone is some 30000 cycles
   task automatic wait_state(input logic [7:0] s);
      int n;
      for (n = 0; n < 600; n++) begin
         repeat (100) @(posedge aclk);
         axi(1'h0, 32'h4, 32'h0, q, r);
         if (q[31:24] === s) break;
      end
      if (n == 600) err_total++;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   initial begin
      cyc(12);
      aresetn <= 1'h1;
      axi(1'h0, 32'h0, 32'h0, q, r);
      `CHK(q, 32'h0)
      axi(1'h1, 32'h0, 32'h2, q, r);
      axi(1'h0, 32'h0, 32'h0, q, r);
      `CHK(q, 32'h2)
      axi(1'h1, 32'h10, 32'h5, q, r);
      `CHK(r, 2'h2)
      axi(1'h0, 32'h10, 32'h0, q, r);
      `CHK({r, q}, {2'h2, 32'h0})
      wait_state(8'h10);
      `CHK(q, 32'h1001_0006)
      `CHK({dual_five_rail, clock_rail_out, active_switch_drive}, 3'h0)
      `CHK({drive.mem25_on, drive.mem33_on}, 2'h2)
      soft_off_req_n <= 1'h0;
      cyc(60);
      stat(32'h1001_0006);
      suspend_ram_req_n <= 1'h1;
      cyc(60);
      stat(32'h1001_0006);
      suspend_ram_req_n <= 1'h0;
      soft_off_req_n <= 1'h1;
      cyc(20);
      // One microsecond wake pulse must be filtered out
      suspend_ram_req_n <= 1'h1;
      cyc(10);
      suspend_ram_req_n <= 1'h0;
      cyc(60);
      stat(32'h1001_0006);
      uv.mem25 <= 1'h1;
      cyc(10);
      `CHK({fault_report, drive.mem25_on}, 2'h2)
      uv <= '0;
      hot <= 2'h1;
      cyc(10);
      `CHK({fault_report, drive.dual3_on}, 2'h3)
      hot <= 2'h3;
      cyc(10);
      `CHK(drive.dual3_on, 1'h0)
      hot <= 2'h0;
      cyc(300);
      `CHK(drive.dual3_on, 1'h1)
      ss_gnd <= 1'h1;
      dual5_sleep_support_en <= 1'h1;
      memory_voltage_select <= 2'h0;
      soft_off_req_n <= 1'h0;
      cyc(10);
      `CHK({drive, fault_report}, 10'h0)
      ss_gnd <= 1'h0;
      wait_state(8'h10);
      `CHK(q, 32'h1002_0012)
      `CHK(dual_five_rail, 1'h1)
      `CHK({drive.mem25_on, drive.mem33_on}, 2'h3)
      dual5_sleep_support_en <= 1'h0;
      cyc(60);
      `CHK(dual_five_rail, 1'h1)
      ss_gnd <= 1'h1;
      cyc(10);
      ss_gnd <= 1'h0;
      wait_state(8'h04);
      uv.dual3 <= 1'h1;
      cyc(10);
      uv <= '0;
      cyc(20);
      `CHK({fault_report, drive.dual3_on}, 2'h2)
      bias_on <= 1'h0;
      cyc(10);
      bias_on <= 1'h1;
      cyc(300);
      `CHK(drive.dual3_on, 1'h1)
      tally_and_finish();
   end

   // Planned run is near 62000 cycles
   initial begin
      #9000000;
      err_total++;
      tally_and_finish();
   end
endmodule

bind aps_sequencer aps_sequencer_properties u_props (.aclk, .aresetn, .sense, .uv, .drive,
   .fault_report, .active_switch_drive, .clock_rail_out);
